// ==== sinc_filter_regs.svh ====
// Register offsets, field positions and reset values of the sinc filter.
//
// Overview of operation
// - Two modulator clocks out, four bitstreams in.
// - Memory data grouped, channels in order.
// - Pointer register holds latest set address.
// - Samples stay between programmed head and tail.
// - One status interrupt; other events are triggers.
// - Transfer completion emits a data trigger.
// - Timer-issued start trigger aligns clocks to PWM.
// - Overload raises status interrupt and trip trigger.
// - Two independent configuration groups.
// - Group members share clock and filter settings.
// - Limits and history exist per channel.
// - Control holds channel enables and group selects.
// - Control masks interrupt; status reports faults, counts.
// - Rate register: primary, secondary decimation, phase.
// - Level register: orders, scale, glitch window, count.
// - Bias offset applied to group primary data.
// - Clock register: frequency, triggered start, phase.
// - Data trigger every count-plus-one transfers.
// - Eight pre-trip secondary outputs kept per channel.
// - Per-channel upper and lower overload thresholds.
// - Glitch filter needs count hits inside window.
// - Saturation and FIFO overflow flagged, masked.
`ifndef SINC_FILTER_REGS_SVH
`define SINC_FILTER_REGS_SVH
// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define O_CTL   8'h00
`define O_STAT  8'h04
`define O_CLK   8'h08
`define O_RATE  8'h10
`define O_LVL   8'h18
`define O_BIAS  8'h20
`define O_HEAD  8'h28
`define O_TAIL  8'h30
`define O_PPTR  8'h38
`define O_LIM   8'h40
`define O_HIST  8'h80
// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define F_EN    0
`define F_GRP   4
`define F_ESAT  8
`define F_EFOVF 10
`define F_ELIM  12
`define F_EPCNT 14
`define F_SOVL  0
`define F_SSAT  4
`define F_SFOVF 6
`define F_SPCNT 8
`define F_SXCNT 16
`define F_MDIV  0
`define F_MCEN  16
`define F_PHASE 24
`define F_PRIMARY_DECIMATION  0
`define F_SECONDARY_DECIMATION  16
`define F_PPH   24
`define F_PRIMARY_ORDER  0
`define F_SECONDARY_ORDER  2
`define F_PSC   4
`define F_TRANSFERS_PER_INTERRUPT  8
`define F_GLITCH_COUNT  16
`define F_GLITCH_WINDOW  20
`define LIM_RST 32'hffff0000
`define SMAX    32'sh00007fff
`define SMIN    -32'sh00008000
`endif

// ==== sinc_filter_pkg.sv ====
// Types shared by the sinc filter design.
`default_nettype none
package sinc_filter_pkg;
  typedef enum logic [1:0] {D_IDLE = 2'b01, D_RUN = 2'b10} dma_st_t;
  typedef struct packed {
    logic [31:0]           ctl;
    logic [31:0]           clk;
    logic [1:0][31:0]      rate;
    logic [1:0][31:0]      lvl;
    logic [1:0][31:0]      bias;
    logic [1:0][31:0]      head;
    logic [1:0][31:0]      tail;
    logic [1:0][31:0]      pptr;
    logic [1:0][31:0]      wp;
    logic [1:0][31:0]      setst;
    logic [3:0][31:0]      lim;
    logic [3:0][7:0][15:0] hist;
    logic [3:0]            ovld;
    logic [3:0]            frz;
    logic [3:0]            ovt;
    logic [3:0]            s1;
    logic [3:0]            s2;
    logic [1:0]            sat;
    logic [1:0]            fovf;
    logic [1:0]            pflag;
    logic [1:0]            pend;
    logic [1:0]            dtr;
    logic [1:0]            run;
    logic [1:0]            mck;
    logic [1:0]            t1;
    logic [1:0]            t2;
    logic [1:0]            t3;
    logic [1:0][7:0]       dcnt;
    logic [1:0][7:0]       xcnt;
    logic [1:0][11:0]      pcn;
    logic [1:0][7:0]       scn;
    logic [3:0][15:0]      pacc;
    logic [3:0][15:0]      sacc;
    logic [3:0][15:0]      pres;
    logic [3:0][3:0]       win;
    logic [3:0][3:0]       hits;
    dma_st_t               dst;
    logic                  dg;
    logic [1:0]            dch;
    logic [7:0]            aq;
    logic                  aw;
    logic                  av;
    logic [31:0]           rd;
  } st_t;
endpackage
`default_nettype wire

// ==== sinc_filter.sv ====
// Sinc decimation filter with AHB-Lite registers, buffer writer and overload trip.
`timescale 1ns/1ns
`default_nettype none
`include "sinc_filter_regs.svh"
module sinc_filter (
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Modulator pins.
  output logic             modulator_clock_out_a,
  output logic             modulator_clock_out_b,
  input  wire logic        bitstream_in_0,
  input  wire logic        bitstream_in_1,
  input  wire logic        bitstream_in_2,
  input  wire logic        bitstream_in_3,
  // Start triggers from the sync delay timer, one per group.
  input  wire logic [1:0]  start_trigger,
  // Buffer write port towards memory.
  output logic             dma_valid,
  input  wire logic        dma_ready,
  output logic [31:0]      dma_addr,
  output logic [15:0]      dma_data,
  // Events.
  output logic             status_irq,
  output logic [1:0]       data_trigger,
  output logic [3:0]       overload_trigger
);
  import sinc_filter_pkg::*;

  st_t s;
  st_t next_s;

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  // Read data is captured in the address phase, so it is a flop output.
  function automatic logic [31:0] rdf(input st_t x, input logic [7:0] a);
    logic [1:0] c;
    logic [1:0] k;
    c = a[6:5];
    k = a[3:2];
    rdf = '0;
    if (a >= `O_HIST) begin
      rdf = {x.hist[c][{k, 1'b1}], x.hist[c][{k, 1'b0}]};
    end else if (a >= `O_LIM && a < `O_HIST) begin
      if (a < `O_LIM + 8'h10) begin
        rdf = x.lim[k];
      end
    end else begin
      case (a)
        `O_CTL:         rdf = x.ctl;
        `O_STAT:        rdf = {x.xcnt[1], x.xcnt[0], 6'h00, x.pflag, x.fovf,
                               x.sat, x.ovld};
        `O_CLK:         rdf = x.clk;
        `O_RATE:        rdf = x.rate[0];
        `O_RATE + 8'h4: rdf = x.rate[1];
        `O_LVL:         rdf = x.lvl[0];
        `O_LVL + 8'h4:  rdf = x.lvl[1];
        `O_BIAS:        rdf = x.bias[0];
        `O_BIAS + 8'h4: rdf = x.bias[1];
        `O_HEAD:        rdf = x.head[0];
        `O_HEAD + 8'h4: rdf = x.head[1];
        `O_TAIL:        rdf = x.tail[0];
        `O_TAIL + 8'h4: rdf = x.tail[1];
        `O_PPTR:        rdf = x.pptr[0];
        `O_PPTR + 8'h4: rdf = x.pptr[1];
        default:        rdf = '0;
      endcase
    end
  endfunction

  // Channel membership of the DMA engine's current channel.
  logic dv;
  assign dv = s.dst == D_RUN && s.ctl[`F_EN + s.dch] &&
              s.ctl[`F_GRP + s.dch] == s.dg;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0]  rise;
    logic [1:0]  pd;
    logic [1:0]  sd;
    logic [1:0]  gen;
    logic        g;
    logic [31:0] v;
    logic [31:0] sh;
    logic [15:0] sv;
    logic [3:0]  nh;
    logic        over;
    rise = '0;
    pd = '0;
    sd = '0;
    gen = '0;
    g = 1'b0;
    v = '0;
    sh = '0;
    sv = '0;
    nh = '0;
    over = 1'b0;
    next_s = s;
    next_s.ovt = '0;
    next_s.dtr = '0;
    // Two flops on every bitstream and start trigger pin before use.
    next_s.s1 = {bitstream_in_3, bitstream_in_2, bitstream_in_1, bitstream_in_0};
    next_s.s2 = s.s1;
    next_s.t1 = start_trigger;
    next_s.t2 = s.t1;
    next_s.t3 = s.t2;
    // Address phase capture; the slave never stretches a transfer.
    next_s.av = hsel && htrans[1] && hready;
    next_s.aw = hwrite;
    next_s.aq = haddr[7:0];
    if (hsel && htrans[1] && hready && !hwrite) begin
      next_s.rd = rdf(s, haddr[7:0]);
    end
    // Register writes come first so hardware sets below win over clears.
    if (s.av && s.aw) begin
      if (s.aq >= `O_LIM && s.aq < `O_LIM + 8'h10) begin
        next_s.lim[s.aq[3:2]] = hwdata;
      end
      case (s.aq)
        `O_CTL:  next_s.ctl = hwdata;
        `O_STAT: begin
          next_s.ovld = s.ovld & ~hwdata[`F_SOVL +: 4];
          next_s.sat = s.sat & ~hwdata[`F_SSAT +: 2];
          next_s.fovf = s.fovf & ~hwdata[`F_SFOVF +: 2];
          next_s.pflag = s.pflag & ~hwdata[`F_SPCNT +: 2];
        end
        `O_CLK:         next_s.clk = hwdata;
        `O_RATE:        next_s.rate[0] = hwdata;
        `O_RATE + 8'h4: next_s.rate[1] = hwdata;
        `O_LVL:         next_s.lvl[0] = hwdata;
        `O_LVL + 8'h4:  next_s.lvl[1] = hwdata;
        `O_BIAS:        next_s.bias[0] = hwdata;
        `O_BIAS + 8'h4: next_s.bias[1] = hwdata;
        `O_HEAD:        begin
          next_s.head[0] = hwdata;
          next_s.wp[0] = hwdata;
        end
        `O_HEAD + 8'h4: begin
          next_s.head[1] = hwdata;
          next_s.wp[1] = hwdata;
        end
        `O_TAIL:        next_s.tail[0] = hwdata;
        `O_TAIL + 8'h4: next_s.tail[1] = hwdata;
        default:        next_s.rd = s.rd;
      endcase
    end
    // Modulator clock per group: off, free run, or start on trigger.
    for (int i = 0; i < 2; i++) begin
      if (s.clk[`F_MCEN + 2 * i +: 2] == 2'h0) begin
        next_s.run[i] = 1'b0;
        next_s.mck[i] = 1'b0;
      end else if (!s.run[i] && (s.clk[`F_MCEN + 2 * i +: 2] == 2'h1 ||
                   (s.t2[i] && !s.t3[i]))) begin
        next_s.run[i] = 1'b1;
        next_s.dcnt[i] = s.clk[`F_PHASE +: 8];
        next_s.pcn[i] = {4'h0, s.rate[i][`F_PPH +: 8]};
      end else if (s.run[i]) begin
        if (s.dcnt[i] >= s.clk[`F_MDIV + 8 * i +: 8]) begin
          next_s.dcnt[i] = '0;
          next_s.mck[i] = !s.mck[i];
          rise[i] = !s.mck[i];
        end else begin
          next_s.dcnt[i] = s.dcnt[i] + 8'h01;
        end
      end
      // Group decimation counters shared by all member channels.
      if (rise[i]) begin
        pd[i] = s.pcn[i] >= s.rate[i][`F_PRIMARY_DECIMATION +: 12] - 12'h001;
        sd[i] = s.scn[i] >= s.rate[i][`F_SECONDARY_DECIMATION +: 8] - 8'h01;
        next_s.pcn[i] = pd[i] ? 12'h000 : s.pcn[i] + 12'h001;
        next_s.scn[i] = sd[i] ? 8'h00 : s.scn[i] + 8'h01;
      end
    end
    // DMA engine walks one group's channels in order.
    case (s.dst)
      D_IDLE: begin
        if (s.pend != 2'b00) begin
          g = !s.pend[0];
          next_s.dg = g;
          next_s.pend[g] = 1'b0;
          next_s.dch = 2'd0;
          next_s.setst[g] = s.wp[g];
          next_s.dst = D_RUN;
        end
      end
      D_RUN: begin
        if (!dv || dma_ready) begin
          if (dv) begin
            next_s.wp[s.dg] = (s.wp[s.dg] == s.tail[s.dg]) ? s.head[s.dg] :
                              s.wp[s.dg] + 32'h2;
          end
          if (s.dch == 2'd3) begin
            next_s.dst = D_IDLE;
            next_s.pptr[s.dg] = s.setst[s.dg];
            if (s.xcnt[s.dg] >= s.lvl[s.dg][`F_TRANSFERS_PER_INTERRUPT +: 8]) begin
              next_s.xcnt[s.dg] = '0;
              next_s.dtr[s.dg] = 1'b1;
              next_s.pflag[s.dg] = 1'b1;
            end else begin
              next_s.xcnt[s.dg] = s.xcnt[s.dg] + 8'h01;
            end
          end else begin
            next_s.dch = s.dch + 2'd1;
          end
        end
      end
      default: next_s.dst = D_IDLE;
    endcase
    // Channel filters: first-order sinc sums of the bitstream.
    for (int c = 0; c < 4; c++) begin
      g = s.ctl[`F_GRP + c];
      if (!s.ctl[`F_EN + c]) begin
        next_s.pacc[c] = '0;
        next_s.sacc[c] = '0;
      end else if (rise[g]) begin
        gen[g] = 1'b1;
        if (pd[g]) begin
          v = {16'h0, s.pacc[c] + {15'h0, s.s2[c]}} + s.bias[g];
          sh = v << s.lvl[g][`F_PSC +: 4];
          if ($signed(sh) > `SMAX || $signed(sh) < `SMIN) begin
            next_s.sat[g] = 1'b1;
            next_s.pres[c] = sh[31] ? 16'h8000 : 16'h7fff;
          end else begin
            next_s.pres[c] = sh[15:0];
          end
          next_s.pacc[c] = '0;
        end else begin
          next_s.pacc[c] = s.pacc[c] + {15'h0, s.s2[c]};
        end
        if (sd[g]) begin
          sv = s.sacc[c] + {15'h0, s.s2[c]};
          next_s.sacc[c] = '0;
          if (!s.frz[c]) begin
            next_s.hist[c] = {s.hist[c][6:0], sv};
          end
          over = sv > s.lim[c][31:16] || sv < s.lim[c][15:0];
          nh = s.hits[c] + {3'h0, over};
          if (over && nh >= s.lvl[g][`F_GLITCH_COUNT +: 4]) begin
            next_s.ovld[c] = 1'b1;
            next_s.ovt[c] = 1'b1;
            next_s.frz[c] = 1'b1;
          end
          if (s.win[c] + 4'h1 >= s.lvl[g][`F_GLITCH_WINDOW +: 4]) begin
            next_s.win[c] = '0;
            next_s.hits[c] = '0;
          end else begin
            next_s.win[c] = s.win[c] + 4'h1;
            next_s.hits[c] = nh;
          end
        end else begin
          next_s.sacc[c] = s.sacc[c] + {15'h0, s.s2[c]};
        end
      end
    end
    // A finished set while the last is unsent overruns the buffer.
    for (int i = 0; i < 2; i++) begin
      if (pd[i] && gen[i]) begin
        if (s.pend[i] || (s.dst == D_RUN && s.dg == i[0])) begin
          next_s.fovf[i] = 1'b1;
        end
        next_s.pend[i] = 1'b1;
      end
    end
    // History stays frozen until software clears the overload flag.
    for (int c = 0; c < 4; c++) begin
      if (!next_s.ovld[c]) begin
        next_s.frz[c] = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.dst <= D_IDLE;
      s.lim <= {4{`LIM_RST}};
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // One interrupt line; everything else leaves as a trigger.
  assign status_irq = |(s.ovld & {s.ctl[`F_ELIM + 1], s.ctl[`F_ELIM + 1],
                                  s.ctl[`F_ELIM], s.ctl[`F_ELIM]}) |
                      |(s.sat & s.ctl[`F_ESAT +: 2]) |
                      |(s.fovf & s.ctl[`F_EFOVF +: 2]) |
                      |(s.pflag & s.ctl[`F_EPCNT +: 2]);
  assign data_trigger = s.dtr;
  assign overload_trigger = s.ovt;
  assign modulator_clock_out_a = s.mck[0];
  assign modulator_clock_out_b = s.mck[1];
  assign dma_valid = dv;
  assign dma_addr = s.wp[s.dg];
  assign dma_data = s.pres[s.dch];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.rd;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence q_last_xfer;
    s.dst == D_RUN && s.dch == 2'd3 && (!dv || dma_ready);
  endsequence
  sequence q_to_tail;
    dv && dma_ready && dma_addr == s.tail[s.dg];
  endsequence

  property p_wrap;
    @(posedge mclk) disable iff (!rst_n)
      q_to_tail |=> s.wp[$past(s.dg)] == s.head[$past(s.dg)];
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap to head");

  property p_step;
    @(posedge mclk) disable iff (!rst_n)
      dv && dma_ready && dma_addr != s.tail[s.dg] |=> s.wp[$past(s.dg)] == $past(dma_addr) + 32'h2;
  endproperty
  a_step: assert property (p_step) else $error("bad address step");

  property p_pptr;
    @(posedge mclk) disable iff (!rst_n)
      q_last_xfer |=> s.pptr[$past(s.dg)] == $past(s.setst[s.dg]) && s.dst == D_IDLE;
  endproperty
  a_pptr: assert property (p_pptr) else $error("pointer not updated");

  property p_dtr;
    @(posedge mclk) disable iff (!rst_n)
      data_trigger[0] |-> $past(s.xcnt[0]) == s.lvl[0][`F_TRANSFERS_PER_INTERRUPT +: 8] && s.xcnt[0] == 8'h00;
  endproperty
  a_dtr: assert property (p_dtr) else $error("trigger count wrong");

  property p_dtr_pulse;
    @(posedge mclk) disable iff (!rst_n)
      data_trigger[1] |=> !data_trigger[1];
  endproperty
  a_dtr_pulse: assert property (p_dtr_pulse) else $error("trigger not a pulse");

  property p_ovl;
    @(posedge mclk) disable iff (!rst_n)
      |overload_trigger |-> (overload_trigger & ~(s.ovld & s.frz)) == 4'h0;
  endproperty
  a_ovl: assert property (p_ovl) else $error("trip without flag");

  property p_irq;
    @(posedge mclk) disable iff (!rst_n)
      (s.ovld[0] && s.ctl[`F_ELIM]) || (s.ovld[2] && s.ctl[`F_ELIM + 1]) |-> status_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("overload irq missing");

  property p_irq_mask;
    @(posedge mclk) disable iff (!rst_n)
      s.ctl[15:8] == 8'h00 |-> !status_irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq seen");

  property p_clk_off;
    @(posedge mclk) disable iff (!rst_n)
      s.clk[`F_MCEN +: 2] == 2'h0 ##1 s.clk[`F_MCEN +: 2] == 2'h0 |-> !modulator_clock_out_a;
  endproperty
  a_clk_off: assert property (p_clk_off) else $error("clock runs when off");

  property p_order;
    @(posedge mclk) disable iff (!rst_n)
      s.dst == D_RUN && s.dch != 2'd3 && (!dv || dma_ready) |=> s.dch == $past(s.dch) + 2'd1;
  endproperty
  a_order: assert property (p_order) else $error("channel order broken");
endmodule
`default_nettype wire

// ==== modulator_model.sv ====
// Behavioural isolated modulators that feed the four bitstream pins.
`timescale 1ns/1ns
`default_nettype none
module modulator_model (
  // Modulator clocks from the filter.
  input  wire logic       clk_a,
  input  wire logic       clk_b,
  // Bitstreams towards the filter.
  output logic      [3:0] bits
);
  logic tog_a = 1'b0;
  logic tog_b = 1'b0;
  // Channels 0 and 2 sit at positive full scale, 1 and 3 at mid scale.
  assign bits = {tog_b, 1'b1, tog_a, 1'b1};
  // Data moves on the falling clock edge so it is settled at the rising sample.
  always @(negedge clk_a) begin
    tog_a <= ~tog_a;
  end
  // Channel 3 follows the other modulator clock; channel 2 is held high.
  always @(negedge clk_b) begin
    tog_b <= ~tog_b;
  end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking testbench of the sinc filter: registers, stream, overload, faults.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        mclk, rst_n, hsel, hwrite, stall, dma_ready, mcb_q, mca_q;
  logic [31:0] haddr, hwdata, d;
  logic [1:0]  htrans, start_trigger;
  logic [2:0]  hsize;
  wire  logic  hreadyout, hresp, mca, mcb, dma_valid, status_irq;
  wire  logic  [31:0] hrdata, dma_addr;
  wire  logic  [15:0] dma_data;
  wire  logic  [1:0]  data_trigger;
  wire  logic  [3:0]  overload_trigger, bits;
  int          err_count, tests_run, n, rcnt, btog, atog;
  int          dtc [2];
  int          ovc [4];
  logic [31:0] qa [$];
  logic [15:0] qd [$];
  logic [7:0]  ra [3] = '{8'h14, 8'h1c, 8'h24};
  logic [31:0] rv [3] = '{32'h01020304, 32'h00123456, 32'h89abcdef};
  // ----------------------------------------------------------------
  // Design and modulators
  // ----------------------------------------------------------------
  sinc_filter DUT (
    .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .modulator_clock_out_a(mca), .modulator_clock_out_b(mcb),
    .bitstream_in_0(bits[0]), .bitstream_in_1(bits[1]), .bitstream_in_2(bits[2]),
    .bitstream_in_3(bits[3]), .start_trigger(start_trigger), .dma_valid(dma_valid),
    .dma_ready(dma_ready), .dma_addr(dma_addr), .dma_data(dma_data),
    .status_irq(status_irq), .data_trigger(data_trigger),
    .overload_trigger(overload_trigger));
  modulator_model MOD (.clk_a(mca), .clk_b(mcb), .bits(bits));
  // The clock inverts every half period of 2 ns.
  always #2 mclk = ~mclk;
  // Memory accepts two cycles in three, or nothing while stalled.
  always @(posedge mclk) begin
    rcnt <= rcnt + 1;
    dma_ready <= !stall && (rcnt % 3 != 0);
  end
  // Monitor of accepted samples, trigger pulses and clock-b activity.
  always @(posedge mclk) begin
    if (dma_valid === 1'b1 && dma_ready === 1'b1) begin
      qa.push_back(dma_addr);
      qd.push_back(dma_data);
    end
    for (int c = 0; c < 4; c++) if (overload_trigger[c] === 1'b1) ovc[c]++;
    for (int c = 0; c < 2; c++) if (data_trigger[c] === 1'b1) dtc[c]++;
    // Counted only out of reset, so the unknown start-up level is no edge.
    if (rst_n === 1'b1 && mcb !== mcb_q) btog++;
    if (rst_n === 1'b1 && mca !== mca_q) atog++;
    mcb_q = mcb;
    mca_q = mca;
  end
  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  // Waits for hready at an edge; a dead slave is left to the watchdog.
  task automatic wait_rdy();
    do begin
      @(posedge mclk);
    end while (hreadyout !== 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    hsel <= 1'b1;
    haddr <= {24'h00, a};
    hwrite <= 1'b1;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= v;
    wait_rdy();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    hsel <= 1'b1;
    haddr <= {24'h00, a};
    hwrite <= 1'b0;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    wait_rdy();
    v = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
      err_count++;
    end
  endtask
  // Reads a register and compares the masked value.
  task automatic rc(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] e,
                    input string m);
    rd(a, d);
    chk(d & mk, e, m);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog, far beyond the few hundred cycles that the tests need.
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    end_of_test();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    {hsel, hwrite, stall, dma_ready, mcb_q, mca_q} = '0;
    {haddr, hwdata, htrans, start_trigger, rcnt, btog, atog} = '0;
    hsize = 3'b010;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    rc(8'h00, '1, 32'h0, "control reset");
    rc(8'h40, '1, 32'hffff0000, "limit reset");
    chk({31'h0, hresp}, 32'h0, "okay response");
    wr(8'h7c, 32'h12345678);
    rc(8'h7c, '1, 32'h0, "unmapped");
    wr(8'h38, 32'h00000100);
    rc(8'h38, '1, 32'h0, "pointer read-only");
    for (int i = 0; i < 3; i++) begin
      wr(ra[i], rv[i]);
      rc(ra[i], '1, rv[i], "group b readback");
      rc(ra[i] - 8'h04, '1, 32'h0, "group a untouched");
    end
    $display("test registers done");
    // Group a: decimation 4, shift 1, two sets per trigger, offset -2.
    wr(8'h10, 32'h00040004);
    wr(8'h18, 32'h00000110);
    wr(8'h20, 32'hfffffffe);
    wr(8'h28, 32'h00001000);
    wr(8'h30, 32'h00001006);
    wr(8'h08, 32'h00090303);
    wr(8'h00, 32'h00000003);
    n = 0;
    while (qa.size() < 12 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    repeat (10) @(posedge mclk);
    rc(8'h38, '1, 32'h00001004, "latest pointer");
    chk(dtc[0], 3, "data triggers a");
    chk(dtc[1], 0, "data triggers b");
    chk(btog, 0, "clock b waits for start");
    chk(atog != 0, 1, "clock a runs");
    // The first set may be partial, so it is left out of the comparison.
    for (int i = 2; i < 12; i++) begin
      chk(qa[i], 32'h1000 + 2 * (i % 4), "address");
      chk({16'h0, qd[i]}, (i % 2 == 0) ? 4 : 0, "sample");
    end
    $display("test stream done");
    // Group b: ch2 above upper limit, ch3 below lower limit.
    wr(8'h14, 32'h00040004);
    wr(8'h1c, 32'h00420000);
    wr(8'h24, 32'h0);
    wr(8'h48, 32'h00020000);
    wr(8'h4c, 32'hffff0003);
    wr(8'h00, 32'h000020cf);
    start_trigger <= 2'b10;
    n = 0;
    while ((ovc[2] == 0 || ovc[3] == 0) && n < 1000) begin
      @(posedge mclk);
      n++;
    end
    @(negedge mclk);
    chk(btog != 0, 1, "clock b started");
    chk(ovc[2] != 0 && ovc[3] != 0, 1, "overload trips");
    chk(ovc[0] + ovc[1], 0, "no trip inside limits");
    chk(status_irq, 1, "overload interrupt");
    rc(8'h04, 32'h0000000f, 32'h0000000c, "overload status");
    rc(8'hc0, 32'h0000ffff, 32'h4, "history ch2");
    rc(8'he0, 32'h0000ffff, 32'h2, "history ch3");
    wr(8'h00, 32'h000000cf);
    @(negedge mclk);
    chk(status_irq, 0, "overload masked");
    wr(8'h48, 32'hffff0000);
    wr(8'h4c, 32'hffff0000);
    repeat (40) @(posedge mclk);
    wr(8'h04, 32'h0000000c);
    rc(8'h04, 32'h0000000f, 32'h0, "status cleared");
    $display("test overload done");
    // Shift 15 saturates ch0 while the memory stalls long enough to overflow.
    wr(8'h18, 32'h000001f0);
    stall <= 1'b1;
    repeat (150) @(posedge mclk);
    rc(8'h04, 32'h00000050, 32'h00000050, "saturation and overflow");
    @(negedge mclk);
    chk(status_irq, 0, "fault masked");
    wr(8'h00, 32'h000005cf);
    @(negedge mclk);
    chk(status_irq, 1, "fault interrupt");
    stall <= 1'b0;
    $display("test faults done");
    end_of_test();
  end
endmodule
`default_nettype wire
